// ==== rtl/lucl_pkg.sv ====
package lucl_pkg;

    // number of monitored live conditions
    localparam int NCOND = 3;

    // register byte offsets on the bus, one aligned word each
    localparam logic [3:0] OFF_LIVE = 4'h0;  // present level of the conditions
    localparam logic [3:0] OFF_LATCH = 4'h4; // latched change bits, clear on read
    localparam logic [3:0] OFF_MASK = 4'h8;  // interrupt enable, same layout as the latch
    localparam logic [3:0] OFF_CTRL = 4'hc;  // line mode control

    // bit positions inside the low byte, shared by live, latch and mask
    localparam int BIT_DRV = 6;  // transmit drive monitor
    localparam int BIT_FIFO = 5; // fifo limit
    localparam int BIT_LOOP = 3; // network loop-code detection

    // control register field
    localparam int BIT_SINGLE_RAIL = 0;

    // implemented bits of each register
    localparam logic [7:0] FIELD_MASK = 8'h68;
    localparam logic [7:0] CTRL_MASK = 8'h01;

    // reset values
    localparam logic [NCOND-1:0] RST_LATCH = 3'h0;
    localparam logic [NCOND-1:0] RST_MASK = 3'h0;
    localparam logic RST_SINGLE_RAIL = 1'b0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // slave answers one cycle after it takes the request
    localparam int ACK_LATENCY = 1;

endpackage : lucl_pkg

// ==== rtl/lucl_chg_if.sv ====
`timescale 1ns/100ps
// live condition levels toward the change detector and its toggle pulses back
interface lucl_chg_if;
    logic [lucl_pkg::NCOND-1:0] live; // index 2 drive, 1 fifo, 0 loop
    logic [lucl_pkg::NCOND-1:0] chg;  // high while live differs from last sample

    // detector side
    modport det (
        input live,
        output chg
    );

    // register core side
    modport core (
        output live,
        input chg
    );
endinterface : lucl_chg_if

// ==== rtl/lucl_change_det.sv ====
`timescale 1ns/100ps
module lucl_change_det (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    // live levels in, toggle pulses out
    lucl_chg_if.det chg_bus
);

    logic [lucl_pkg::NCOND-1:0] prev_ff; // level seen at the last enabled edge
    logic prime_ff;                      // set once prev_ff holds a real sample

    // a condition that is already high out of reset is not a change: wait one sample
    assign chg_bus.chg = prime_ff ? (chg_bus.live ^ prev_ff) : '0;

    // sample the live levels on every enabled edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= '0;
            prime_ff <= 1'b0;
        end else if (ce) begin
            prev_ff <= chg_bus.live;
            prime_ff <= 1'b1;
        end
    end

    // a toggle shows for one enabled cycle only when the level holds
    toggle_once_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ce && chg_bus.chg != '0) ##1 $stable(chg_bus.live)
        |-> chg_bus.chg == '0)
        else $error("toggle pulse did not end after one sample");

endmodule : lucl_change_det

// ==== rtl/lucl_top.sv ====
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module lucl_top #(
    parameter int ADDR_W = 4 // byte address bits decoded
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    // classic wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // live conditions from the line interface unit
    input wire logic drive_monitor_live_status,
    input wire logic fifo_limit_live_status,
    input wire logic loop_code_live_status,
    // interrupt toward the host
    output logic irq
);

    // latched change bits, index 2 drive, 1 fifo, 0 loop
    logic [lucl_pkg::NCOND-1:0] line_unit_change_latch_ff;
    logic [lucl_pkg::NCOND-1:0] nxt_line_unit_change_latch;
    // interrupt enable bits, same layout as the latch
    logic [lucl_pkg::NCOND-1:0] mask_ff;
    logic [lucl_pkg::NCOND-1:0] nxt_mask;
    // line mode: change capture runs only in single rail mode
    logic single_rail_ff;
    logic nxt_single_rail;
    // bus answer registers
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // packs three condition bits into their byte positions
    function automatic logic [7:0] to_reg(input logic [lucl_pkg::NCOND-1:0] v);
        logic [7:0] r;
        // unused positions stay zero
        r = 8'h00;
        r[lucl_pkg::BIT_DRV] = v[2];
        r[lucl_pkg::BIT_FIFO] = v[1];
        r[lucl_pkg::BIT_LOOP] = v[0];
        return r;
    endfunction : to_reg

    // picks the three condition bits back out of a byte
    function automatic logic [lucl_pkg::NCOND-1:0] from_reg(input logic [7:0] r);
        return {r[lucl_pkg::BIT_DRV], r[lucl_pkg::BIT_FIFO], r[lucl_pkg::BIT_LOOP]};
    endfunction : from_reg

    // change detector sits behind its own carrier
    // the detector owns its sample register; this module only reads the pulses
    lucl_chg_if chg_bus ();

    // live levels packed for the detector and for the live register
    assign chg_bus.live = {drive_monitor_live_status, fifo_limit_live_status,
                           loop_code_live_status};

    // the detector runs on the same enable so a toggle during a freeze stays on chg and is latched once ce rises
    lucl_change_det u_det (
        .ref_clk (ref_clk),
        .arst_n (arst_n),
        .ce (ce),
        .chg_bus (chg_bus)
    );

    // request decode: taken on the first enabled cycle, before ack goes out
    // the !ack_ff term stops a held request from being taken a second time
    // while its answer is on the bus; the master drops cyc on that same edge
    // exact match on the whole byte address, so an unaligned access hits nothing
    wire take = wb_cyc && wb_stb && !ack_ff && ce;
    wire take_rd = take && !wb_we;
    wire take_wr = take && wb_we && wb_sel[0]; // every field lives in byte lane 0
    wire hit_live = (wb_adr == ADDR_W'(lucl_pkg::OFF_LIVE));
    wire hit_latch = (wb_adr == ADDR_W'(lucl_pkg::OFF_LATCH));
    wire hit_mask = (wb_adr == ADDR_W'(lucl_pkg::OFF_MASK));
    wire hit_ctrl = (wb_adr == ADDR_W'(lucl_pkg::OFF_CTRL));

    // capture gate: changes outside single rail mode are meaningless and dropped
    // a limitation: a toggle seen while the mode is off is never reported later
    wire [lucl_pkg::NCOND-1:0] set_vec = chg_bus.chg & {lucl_pkg::NCOND{single_rail_ff}};

    // clear sources: a read of the latch clears all, a write of ones clears chosen bits
    // a zero written to a latch bit leaves it alone, so one flag can be cleared
    wire rd_clear = take_rd && hit_latch;
    wire [lucl_pkg::NCOND-1:0] wr_clear =
        (take_wr && hit_latch) ? from_reg(wb_dat_w[7:0]) : '0;
    wire [lucl_pkg::NCOND-1:0] clr_vec = rd_clear ? '1 : wr_clear;

    // set wins over clear so a change landing on the read cycle is kept for next read
    assign nxt_line_unit_change_latch =
        (line_unit_change_latch_ff & ~clr_vec) | set_vec;

    // mask and mode registers follow plain writes
    // writes land on the taking edge, a cycle before the ack is seen
    assign nxt_mask = (take_wr && hit_mask) ? from_reg(wb_dat_w[7:0]) : mask_ff;
    assign nxt_single_rail = (take_wr && hit_ctrl) ?
        wb_dat_w[lucl_pkg::BIT_SINGLE_RAIL] : single_rail_ff;

    // read selection; unused and reserved bits, and unmapped offsets, read zero
    // the live byte is a plain view of the pins, so a read never disturbs it
    wire [7:0] live_byte = to_reg(chg_bus.live);
    wire [7:0] latch_byte = to_reg(line_unit_change_latch_ff) & lucl_pkg::FIELD_MASK;
    wire [7:0] mask_byte = to_reg(mask_ff);
    wire [7:0] ctrl_byte = {7'h00, single_rail_ff} & lucl_pkg::CTRL_MASK;
    wire [7:0] rd_byte = hit_live ? live_byte :
                         hit_latch ? latch_byte :
                         hit_mask ? mask_byte :
                         hit_ctrl ? ctrl_byte : 8'h00;
    // read data is captured with the old latch value, the clear lands on the same edge
    assign nxt_rdata = take_rd ? {24'h00_0000, rd_byte} : rdata_ff;

    // latched change bits come out of reset empty
    // ce low holds the latch; a change shows once the detector runs again
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_unit_change_latch_ff <= lucl_pkg::RST_LATCH;
        end else if (ce) begin
            line_unit_change_latch_ff <= nxt_line_unit_change_latch;
        end
    end

    // software control registers
    // both are plain read-write fields with no side effect on read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_ff <= lucl_pkg::RST_MASK;
            single_rail_ff <= lucl_pkg::RST_SINGLE_RAIL;
        end else if (ce) begin
            mask_ff <= nxt_mask;
            single_rail_ff <= nxt_single_rail;
        end
    end

    // bus answer: one wait state, ack is a single-cycle pulse per request
    // rdata only moves on a taken read, so a late sample of it still holds
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= lucl_pkg::RST_RDATA;
        end else if (ce) begin
            ack_ff <= take;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs straight from the answer flops, no logic after them
    assign wb_ack = ack_ff;
    assign wb_dat_r = rdata_ff;

    // level interrupt while any enabled change bit is held
    // it stays high until the flag is read or cleared, or its mask bit drops
    assign irq = |(line_unit_change_latch_ff & mask_ff);

    // checks on the behaviour above; they share the bus clock and the reset
    // and stay quiet while reset is low
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // answer latency, taken from the shared constants
    localparam int ACK_LO = lucl_pkg::ACK_LATENCY; // ack arrives one cycle after the take
    localparam int ACK_HI = lucl_pkg::ACK_LATENCY;

    // a change seen while capture is live, whether or not a read clears on that edge
    sequence drv_change_s;
        ce && single_rail_ff && chg_bus.chg[2];
    endsequence
    sequence fifo_change_s;
        ce && single_rail_ff && chg_bus.chg[1];
    endsequence
    sequence loop_change_s;
        ce && single_rail_ff && chg_bus.chg[0];
    endsequence

    // a read of the latch taken, and the answer that follows it
    sequence latch_read_s;
        take_rd && hit_latch;
    endsequence
    sequence answer_s;
        ##ACK_LO wb_ack ##1 (!wb_ack || !$past(ce));
    endsequence

    drive_flag_set_a: assert property (drv_change_s |=> latch_byte[6])
        else $error("drive monitor change not latched");

    fifo_flag_set_a: assert property (fifo_change_s |=> latch_byte[5])
        else $error("fifo limit change not latched");

    loop_flag_set_a: assert property (loop_change_s |=> latch_byte[3])
        else $error("loop-code change not latched");

    // with no new change on that edge, a read leaves the latch empty
    read_clears_a: assert property ((latch_read_s and (set_vec == '0))
        |=> line_unit_change_latch_ff == '0)
        else $error("latch not cleared by read");

    // a change on the read edge survives the clear
    set_beats_read_a: assert property ((latch_read_s and drv_change_s)
        |=> line_unit_change_latch_ff[2])
        else $error("change lost on read cycle");

    // a set bit stays until the host clears it
    flag_sticky_a: assert property ((ce && line_unit_change_latch_ff[1] && !rd_clear &&
        !wr_clear[1]) |=> line_unit_change_latch_ff[1])
        else $error("fifo change flag dropped without a clear");

    // a clear bit stays clear without a change
    flag_quiet_a: assert property ((!line_unit_change_latch_ff[0] && !set_vec[0])
        |=> !line_unit_change_latch_ff[0])
        else $error("loop change flag set without a change");

    // the answer of a latch read holds zero in bits 7, 4, 2 and 31:8
    reserved_zero_a: assert property (latch_read_s |-> ##ACK_LO (wb_ack &&
        wb_dat_r[7] == 1'b0 && wb_dat_r[4] == 1'b0 && wb_dat_r[2] == 1'b0 &&
        wb_dat_r[31:8] == 24'h00_0000))
        else $error("reserved latch bits read nonzero");

    // a live read returns the level present when it was taken
    live_read_a: assert property ((take_rd && hit_live) |=>
        (wb_dat_r[lucl_pkg::BIT_DRV] == $past(drive_monitor_live_status) &&
        wb_dat_r[lucl_pkg::BIT_FIFO] == $past(fifo_limit_live_status) &&
        wb_dat_r[lucl_pkg::BIT_LOOP] == $past(loop_code_live_status)))
        else $error("live status read mismatch");

    // an enabled change raises the interrupt on the next edge
    irq_raise_a: assert property ((drv_change_s and mask_ff[2] and !(take_wr && hit_mask))
        |=> irq)
        else $error("enabled change did not raise interrupt");

    // nothing is captured before software selects single rail mode
    no_capture_a: assert property ((!single_rail_ff && line_unit_change_latch_ff == '0 &&
        !(take_wr && hit_ctrl)) |=> line_unit_change_latch_ff == '0)
        else $error("change captured outside single rail mode");

    // every taken request is answered once, a cycle later
    bus_answer_a: assert property (take |-> answer_s)
        else $error("bus answer timing wrong");

    // ack never comes without a request taken the cycle before
    ack_cause_a: assert property ((wb_ack && $past(ce)) |-> $past(take, ACK_HI))
        else $error("ack without a request");

    // a write of one to a latch bit clears it when no change lands with it
    wc_clears_a: assert property ((take_wr && hit_latch && wb_dat_w[lucl_pkg::BIT_DRV] &&
        !set_vec[2]) |=> !line_unit_change_latch_ff[2])
        else $error("write of one did not clear the drive change flag");

    // a write of zero leaves a set latch bit in place
    wz_keeps_a: assert property ((take_wr && hit_latch && !wb_dat_w[lucl_pkg::BIT_FIFO] &&
        line_unit_change_latch_ff[1]) |=> line_unit_change_latch_ff[1])
        else $error("write of zero dropped the fifo change flag");

    // the mask register takes the enable bits of a byte lane 0 write
    mask_write_a: assert property ((take_wr && hit_mask) |=>
        (mask_ff == {$past(wb_dat_w[lucl_pkg::BIT_DRV]), $past(wb_dat_w[lucl_pkg::BIT_FIFO]),
        $past(wb_dat_w[lucl_pkg::BIT_LOOP])}))
        else $error("mask register write mismatch");

    // the mode bit follows a control write
    mode_write_a: assert property ((take_wr && hit_ctrl) |=>
        single_rail_ff == $past(wb_dat_w[lucl_pkg::BIT_SINGLE_RAIL]))
        else $error("single rail mode write mismatch");

    // control and mask reads return what was written
    ctrl_read_a: assert property ((take_rd && hit_ctrl) |=>
        wb_dat_r == {31'h0, $past(single_rail_ff)})
        else $error("control register read mismatch");

    mask_read_a: assert property ((take_rd && hit_mask) |=>
        (wb_dat_r[lucl_pkg::BIT_DRV] == $past(mask_ff[2]) &&
        wb_dat_r[lucl_pkg::BIT_FIFO] == $past(mask_ff[1]) &&
        wb_dat_r[lucl_pkg::BIT_LOOP] == $past(mask_ff[0]) &&
        (wb_dat_r & ~32'(lucl_pkg::FIELD_MASK)) == 32'h0000_0000))
        else $error("mask register read mismatch");

    // reading the latch with no new change drops the interrupt
    irq_drop_a: assert property ((latch_read_s and (set_vec == '0)) |=> !irq)
        else $error("interrupt held after the latch was read");

    // with nothing enabled pending or arriving, the interrupt stays low
    masked_quiet_a: assert property ((ce && (set_vec & mask_ff) == '0 &&
        (line_unit_change_latch_ff & mask_ff) == '0 &&
        !(take_wr && hit_mask)) |=> !irq)
        else $error("interrupt raised without an enabled change");

    // read data carries the latch as it stood before the clear
    read_old_a: assert property (latch_read_s |=>
        wb_dat_r[lucl_pkg::BIT_LOOP] == $past(line_unit_change_latch_ff[0]))
        else $error("latch read returned the value after the clear");

    // a latched fifo change shows in the answer of the read that clears it
    read_shows_a: assert property ((latch_read_s and line_unit_change_latch_ff[1]) |->
        ##ACK_LO wb_dat_r[lucl_pkg::BIT_FIFO])
        else $error("latched fifo change missing from the read answer");

    // a clear drive flag stays clear without a change
    drv_quiet_a: assert property ((!line_unit_change_latch_ff[2] && !set_vec[2])
        |=> !line_unit_change_latch_ff[2])
        else $error("drive change flag set without a change");

    // an unmapped offset reads as zero
    unmapped_zero_a: assert property ((take_rd && !hit_live && !hit_latch && !hit_mask &&
        !hit_ctrl) |=> wb_dat_r == 32'h0000_0000)
        else $error("unmapped offset read nonzero");

    // a request is taken once, its ack pulse blocks a second take
    one_take_a: assert property (take |=> !take)
        else $error("request taken twice");

    // ack is a single pulse while the clock is enabled
    ack_pulse_a: assert property ((wb_ack && ce) |=> !wb_ack)
        else $error("ack held for more than one cycle");

    // read data only moves when a read is taken
    rdata_hold_a: assert property ((ce && !take_rd) |=> $stable(wb_dat_r))
        else $error("read data changed without a read");

    // a low clock enable freezes every register, the bus answer too
    freeze_state_a: assert property (!ce |=> ($stable(line_unit_change_latch_ff) &&
        $stable(mask_ff) && $stable(single_rail_ff)))
        else $error("state moved while the clock enable was low");

    freeze_bus_a: assert property (!ce |=> ($stable(wb_ack) && $stable(wb_dat_r)))
        else $error("bus answer moved while the clock enable was low");

    // a change held back by a low enable is latched on the first enabled edge
    sequence thaw_s;
        !ce ##1 (ce && single_rail_ff && chg_bus.chg[0]);
    endsequence
    thaw_capture_a: assert property (thaw_s |=> line_unit_change_latch_ff[0])
        else $error("held-back loop-code change not latched");

endmodule : lucl_top

// ==== tb/lucl_top_tb.sv ====
`timescale 1ns/100ps
module lucl_top_tb;
    // clock, reset, enable; ce is lowered once to exercise the freeze
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    // classic wishbone master side
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    // live levels: index 2 drive monitor, 1 fifo limit, 0 loop-code
    logic [2:0] live = 3'h0;
    logic irq;
    // bookkeeping
    int num_errors = 0;
    int comparisons = 0;
    logic [31:0] rd;
    // latch bit that belongs to each live index
    logic [31:0] bit_of [3] = '{32'h08, 32'h20, 32'h40};

    // 100 mhz clock
    always #5 ref_clk = ~ref_clk;

    lucl_top u_dut (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ce(ce),
        .wb_cyc(wb_cyc),
        .wb_stb(wb_stb),
        .wb_we(wb_we),
        .wb_adr(wb_adr),
        .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack),
        .drive_monitor_live_status(live[2]),
        .fifo_limit_live_status(live[1]),
        .loop_code_live_status(live[0]),
        .irq(irq)
    );

    // compare and count; case inequality so an unknown never matches
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is seen at a rising edge
    task wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hf;
        wb_dat_w <= dat;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        // a missing ack counts as a mismatch, not a hang
        if (wb_ack !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, wb_ack, 1'b1);
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_xfer

    task wr(input logic [3:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask : wr

    task rdc(input logic [3:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdc

    // flip one live level, then give latch and irq time to follow
    task tog(input int idx);
        @(posedge ref_clk);
        live[idx] <= ~live[idx];
        repeat (2) @(posedge ref_clk);
    endtask : tog

    task test_done(input string name);
        $display("test %s done, errors so far %0d", name, num_errors);
    endtask : test_done

    task finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // watchdog: the whole sequence needs well under 10 us
    initial begin
        #50000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdc(4'h4, 32'h0);
        rdc(4'h8, 32'h0);
        rdc(4'h0, 32'h0);
        chk({31'h0, irq}, 32'h0);
        test_done("reset");
        // single rail on, then each condition on its own, both directions
        wr(4'hc, 32'h1);
        rdc(4'hc, 32'h1);
        for (int i = 0; i < 3; i++) begin
            tog(i);
            rdc(4'h0, bit_of[i]);
            rdc(4'h4, bit_of[i]);
            rdc(4'h4, 32'h0);
            tog(i);
            rdc(4'h4, bit_of[i]);
        end
        test_done("single toggles");
        // a toggle and its return between reads still leaves a one
        tog(2);
        tog(2);
        rdc(4'h4, 32'h40);
        @(posedge ref_clk);
        live <= 3'h7;
        repeat (2) @(posedge ref_clk);
        rdc(4'h0, 32'h68);
        rdc(4'h4, 32'h68);
        // write-one-to-clear removes only the written bit
        @(posedge ref_clk);
        live <= 3'h0;
        repeat (2) @(posedge ref_clk);
        wr(4'h4, 32'h40);
        rdc(4'h4, 32'h28);
        rdc(4'h4, 32'h0);
        test_done("multi toggles");
        // reserved bits, read-only live, unaligned address
        wr(4'h8, 32'hffff_ffff);
        rdc(4'h8, 32'h68);
        wr(4'h0, 32'hffff_ffff);
        rdc(4'h0, 32'h0);
        rdc(4'h2, 32'h0);
        test_done("reserved");
        // only an enabled change drives the interrupt
        wr(4'h8, 32'h40);
        tog(1);
        chk({31'h0, irq}, 32'h0);
        tog(2);
        chk({31'h0, irq}, 32'h1);
        rdc(4'h4, 32'h60);
        chk({31'h0, irq}, 32'h0);
        test_done("interrupt");
        // with single rail off a change leaves no trace
        wr(4'hc, 32'h0);
        tog(0);
        rdc(4'h4, 32'h0);
        test_done("single rail off");
        // a low enable freezes capture; the held-back change lands once it rises
        wr(4'hc, 32'h1);
        wr(4'h8, 32'h08);
        @(posedge ref_clk);
        ce <= 1'b0;
        tog(0);
        chk({31'h0, irq}, 32'h0);
        @(posedge ref_clk);
        ce <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        rdc(4'h4, 32'h08);
        test_done("freeze");
        // a reset in mid-run empties latch, mask and mode and drops the interrupt
        tog(0);
        chk({31'h0, irq}, 32'h1);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        @(posedge ref_clk);
        arst_n <= 1'b1;
        chk({31'h0, irq}, 32'h0);
        rdc(4'h4, 32'h0);
        rdc(4'h8, 32'h0);
        rdc(4'hc, 32'h0);
        test_done("mid reset");
        finish_test();
    end
endmodule : lucl_top_tb
